// file: inc/rct_defines.svh
`ifndef RCT_DEFINES_SVH
`define RCT_DEFINES_SVH

// apb geometry: byte address is four times the register index
`define RCT_ADDR_W        16
`define RCT_IDX_W         14

// register word indices
`define RCT_IDX_PORT      14'h0006
`define RCT_IDX_INTCTL_A  14'h000B
`define RCT_IDX_INTCTL_B  14'h008B
`define RCT_IDX_OPTION    14'h0081
`define RCT_IDX_DIR       14'h0086
`define RCT_IDX_CAUSE_REG 14'h008E
`define RCT_IDX_CONFIG    14'h2007
// extra registers
`define RCT_IDX_FLAGS     14'h0090
`define RCT_IDX_LAST      14'h0091
`define RCT_IDX_IRQ_STAT  14'h0092
`define RCT_IDX_IRQ_EN    14'h0093
`define RCT_IDX_IRQ_CLR   14'h0094

// field positions
`define RCT_POR_BIT       1
`define RCT_FLAG_PDN_BIT  0
`define RCT_FLAG_TMO_BIT  1
`define RCT_INTCTL_KEEP   0

// reset values
`define RCT_DIR_RST       8'hFF
`define RCT_OPTION_RST    8'hFF
`define RCT_POWERON_FILL  8'h00
`define RCT_INTCTL_RST    7'h00

// event bits in the interrupt registers
`define RCT_EVT_W         4
`define RCT_EVT_PIN_RUN   0
`define RCT_EVT_PIN_SLP   1
`define RCT_EVT_DOG_RUN   2
`define RCT_EVT_DOG_WAKE  3

// timing: clock period and shortest accepted reset-pin low time
`define RCT_CLK_PERIOD_NS 100
`define RCT_PIN_MIN_NS    2000
`define RCT_PIN_MIN_CYC   ((`RCT_PIN_MIN_NS + `RCT_CLK_PERIOD_NS - 1) / `RCT_CLK_PERIOD_NS)
`define RCT_CNT_W         8

`endif

// file: inc/rct_pkg.sv
package rct_pkg;
  // the five distinguished reset conditions, in this order
  typedef enum logic [2:0] {
    RCT_CAUSE_POR,
    RCT_CAUSE_PIN_RUN,
    RCT_CAUSE_PIN_SLEEP,
    RCT_CAUSE_DOG_RUN,
    RCT_CAUSE_DOG_WAKE
  } rct_cause_type;

  // reset-pin filter states
  typedef enum logic [1:0] {
    RCT_FILT_IDLE,
    RCT_FILT_COUNT,
    RCT_FILT_HELD
  } rct_filt_type;
endpackage : rct_pkg

// file: inc/rct_evt_if.sv
`timescale 1ns/1ps
interface rct_evt_if import rct_pkg::*; ();
  logic          pin_hold;     // filtered pin is asserted
  logic          pin_event;    // one cycle at filtered assertion
  logic          dog_event;    // watchdog timeout pulse
  logic          sleep_active; // core is sleeping
  rct_cause_type cause;        // classified cause
  logic          cause_valid;  // one cycle with a new cause

  modport filt (output pin_hold, pin_event);
  modport dec  (input pin_event, dog_event, sleep_active, output cause, cause_valid);
  modport top  (input pin_hold, cause, cause_valid, output dog_event, sleep_active);
endinterface : rct_evt_if

// file: rtl/rct_pin_filter.sv
`timescale 1ns/1ps
`include "rct_defines.svh"
module rct_pin_filter import rct_pkg::*; (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // raw pin, active low, asynchronous
  input  wire logic external_reset_pin_n,
  // filtered result
  rct_evt_if.filt   evt
);
  logic                 sync1_reg;  // first stage, read only by stage two
  logic                 sync2_reg;  // safe copy of the pin
  logic [`RCT_CNT_W-1:0] cnt_reg;   // cycles seen low
  rct_filt_type         state_reg;

  // two-flop synchroniser; idles high (pin released)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= external_reset_pin_n;
      sync2_reg <= sync1_reg;
    end
  end

  // a low pulse only counts once it outlasts the minimum width;
  // any bounce back high before then restarts the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= RCT_FILT_IDLE;
      cnt_reg       <= '0;
      evt.pin_hold  <= 1'b0;
      evt.pin_event <= 1'b0;
    end else begin
      evt.pin_event <= 1'b0;
      unique case (state_reg)
        RCT_FILT_IDLE: begin
          cnt_reg <= '0;
          if (!sync2_reg) begin
            state_reg <= RCT_FILT_COUNT;
          end
        end
        RCT_FILT_COUNT: begin
          if (sync2_reg) begin // short pulse: ignored
            state_reg <= RCT_FILT_IDLE;
          end else if (cnt_reg == `RCT_CNT_W'(`RCT_PIN_MIN_CYC - 1)) begin
            state_reg     <= RCT_FILT_HELD;
            evt.pin_hold  <= 1'b1;
            evt.pin_event <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        RCT_FILT_HELD: begin
          // release on the first high sample
          if (sync2_reg) begin
            state_reg    <= RCT_FILT_IDLE;
            evt.pin_hold <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule : rct_pin_filter

// file: rtl/rct_cause_decode.sv
`timescale 1ns/1ps
module rct_cause_decode import rct_pkg::*; (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // events in, cause out
  rct_evt_if.dec    evt
);
  // classify each event by whether the core sleeps; the pin wins if
  // both land in the same cycle since it is the stronger reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt.cause       <= RCT_CAUSE_POR;
      evt.cause_valid <= 1'b0;
    end else begin
      evt.cause_valid <= evt.pin_event | evt.dog_event;
      if (evt.pin_event) begin
        evt.cause <= evt.sleep_active ? RCT_CAUSE_PIN_SLEEP : RCT_CAUSE_PIN_RUN;
      end else if (evt.dog_event) begin
        evt.cause <= evt.sleep_active ? RCT_CAUSE_DOG_WAKE : RCT_CAUSE_DOG_RUN;
      end
    end
  end
endmodule : rct_cause_decode

// file: rtl/rct_top.sv
`timescale 1ns/1ps
`include "rct_defines.svh"
module rct_top import rct_pkg::*; (
  // clock and power-on reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RCT_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // reset sources
  input  wire logic                   external_reset_pin_n,
  input  wire logic                   watchdog_timer_timeout,
  input  wire logic                   core_sleeping,
  // register contents towards the core
  output logic      [7:0]             port_output_latch,
  output logic      [7:0]             port_direction,
  output logic      [7:0]             option_settings,
  output logic      [7:0]             interrupt_control,
  // reset and wake requests to the core
  output logic                        core_reset,
  output logic                        core_wake,
  // interrupt
  output logic                        irq
);
  rct_evt_if evt ();

  // register state
  logic [7:0]            port_output_latch_reg;
  logic [7:0]            port_direction_reg;
  logic [7:0]            option_reg;
  logic [7:0]            intctl_reg;
  logic [7:0]            config_word_reg;
  logic                  por_flag_reg;   // 0 = power-on happened
  logic                  timeout_flag_reg;
  logic                  power_down_flag_reg;
  rct_cause_type         last_cause_reg;
  logic [`RCT_EVT_W-1:0] irq_status_reg;
  logic [`RCT_EVT_W-1:0] irq_enable_reg;
  // bus and output flops
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic                  core_reset_reg;
  logic                  core_wake_reg;
  logic                  irq_reg;
  // decoded strobes
  logic                  load_defaults;
  logic                  wr_done;
  logic                  rd_take;
  logic [`RCT_IDX_W-1:0] idx;
  logic [`RCT_EVT_W-1:0] evt_set;
  logic [`RCT_EVT_W-1:0] evt_clr;
  logic [31:0]           rd_value;

  // same-clock sources go straight in
  assign evt.dog_event    = watchdog_timer_timeout;
  assign evt.sleep_active = core_sleeping;

  rct_pin_filter u_filter (
    .pclk                 (pclk),
    .presetn              (presetn),
    .external_reset_pin_n (external_reset_pin_n),
    .evt                  (evt)
  );

  rct_cause_decode u_decode (
    .pclk    (pclk),
    .presetn (presetn),
    .evt     (evt)
  );

  // true when the index names a mapped register
  function automatic logic rct_is_mapped(input logic [`RCT_IDX_W-1:0] i);
    unique case (i)
      `RCT_IDX_PORT, `RCT_IDX_INTCTL_A, `RCT_IDX_INTCTL_B, `RCT_IDX_OPTION,
      `RCT_IDX_DIR, `RCT_IDX_CAUSE_REG, `RCT_IDX_CONFIG, `RCT_IDX_FLAGS,
      `RCT_IDX_LAST, `RCT_IDX_IRQ_STAT, `RCT_IDX_IRQ_EN,
      `RCT_IDX_IRQ_CLR: rct_is_mapped = 1'b1;
      default:          rct_is_mapped = 1'b0;
    endcase
  endfunction : rct_is_mapped

  // one-hot event vector from a cause pulse
  function automatic logic [`RCT_EVT_W-1:0] rct_evt_bits(input logic v, input rct_cause_type c);
    rct_evt_bits = '0;
    if (v) begin
      unique case (c)
        RCT_CAUSE_PIN_RUN:   rct_evt_bits[`RCT_EVT_PIN_RUN]  = 1'b1;
        RCT_CAUSE_PIN_SLEEP: rct_evt_bits[`RCT_EVT_PIN_SLP]  = 1'b1;
        RCT_CAUSE_DOG_RUN:   rct_evt_bits[`RCT_EVT_DOG_RUN]  = 1'b1;
        RCT_CAUSE_DOG_WAKE:  rct_evt_bits[`RCT_EVT_DOG_WAKE] = 1'b1;
        default:             rct_evt_bits = '0;
      endcase
    end
  endfunction : rct_evt_bits

  // word index; the two low address bits are ignored
  assign idx     = paddr[`RCT_ADDR_W-1:2];
  // a write lands only on the edge where pready is seen high
  assign wr_done = psel & penable & pready_reg & pwrite;
  // read data is captured in the first access cycle
  assign rd_take = psel & penable & ~pready_reg;
  assign evt_set = rct_evt_bits(evt.cause_valid, evt.cause);
  assign evt_clr = (wr_done && idx == `RCT_IDX_IRQ_CLR) ? pwdata[`RCT_EVT_W-1:0] : '0;

  // pin held or watchdog in run: defaults; wake-up never loads them
  assign load_defaults = evt.pin_hold
                       | (evt.cause_valid && evt.cause == RCT_CAUSE_DOG_RUN);

  // read mux; unimplemented bits read as zero
  always_comb begin
    rd_value = '0;
    unique case (idx)
      `RCT_IDX_PORT:                       rd_value[7:0] = port_output_latch_reg;
      `RCT_IDX_INTCTL_A, `RCT_IDX_INTCTL_B: rd_value[7:0] = intctl_reg;
      `RCT_IDX_OPTION:                     rd_value[7:0] = option_reg;
      `RCT_IDX_DIR:                        rd_value[7:0] = port_direction_reg;
      `RCT_IDX_CAUSE_REG:                  rd_value[`RCT_POR_BIT] = por_flag_reg;
      `RCT_IDX_CONFIG:                     rd_value[7:0] = config_word_reg;
      `RCT_IDX_FLAGS: begin
        rd_value[`RCT_FLAG_TMO_BIT] = timeout_flag_reg;
        rd_value[`RCT_FLAG_PDN_BIT] = power_down_flag_reg;
      end
      `RCT_IDX_LAST:                       rd_value[2:0] = last_cause_reg;
      `RCT_IDX_IRQ_STAT:                   rd_value[`RCT_EVT_W-1:0] = irq_status_reg;
      `RCT_IDX_IRQ_EN:                     rd_value[`RCT_EVT_W-1:0] = irq_enable_reg;
      default:                             rd_value = '0; // clear register reads zero
    endcase
  end

  // apb handshake: one wait state, so every access takes two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= rd_take;
      if (rd_take) begin
        prdata_reg  <= pwrite ? '0 : rd_value;
        pslverr_reg <= ~rct_is_mapped(idx);
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // port latch: power-on is the only reset that touches it; the fill value is arbitrary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_output_latch_reg <= `RCT_POWERON_FILL;
    end else if (wr_done && idx == `RCT_IDX_PORT) begin
      port_output_latch_reg <= pwdata[7:0];
    end
  end

  // configuration word survives every reset but power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_word_reg <= `RCT_POWERON_FILL;
    end else if (wr_done && idx == `RCT_IDX_CONFIG) begin
      config_word_reg <= pwdata[7:0];
    end
  end

  // direction and option: defaults win over a write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_direction_reg <= `RCT_DIR_RST;
      option_reg         <= `RCT_OPTION_RST;
    end else if (load_defaults) begin
      port_direction_reg <= `RCT_DIR_RST;
      option_reg         <= `RCT_OPTION_RST;
    end else if (wr_done) begin
      if (idx == `RCT_IDX_DIR) begin
        port_direction_reg <= pwdata[7:0];
      end
      if (idx == `RCT_IDX_OPTION) begin
        option_reg <= pwdata[7:0];
      end
    end
  end

  // interrupt control: two aliases; bit 0 is left alone by every reset but power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_reg <= '0;
    end else if (load_defaults) begin
      intctl_reg <= {`RCT_INTCTL_RST, intctl_reg[`RCT_INTCTL_KEEP]};
    end else if (wr_done && (idx == `RCT_IDX_INTCTL_A || idx == `RCT_IDX_INTCTL_B)) begin
      intctl_reg <= pwdata[7:0];
    end
  end

  // power-on flag: cleared by power-on, software may write it either way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_flag_reg <= 1'b0;
    end else if (wr_done && idx == `RCT_IDX_CAUSE_REG) begin
      por_flag_reg <= pwdata[`RCT_POR_BIT];
    end
  end

  // timeout and power-down flags track the classified cause;
  // a pin reset in run leaves both as they were
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_reg    <= 1'b1;
      power_down_flag_reg <= 1'b1;
      last_cause_reg      <= RCT_CAUSE_POR;
    end else if (evt.cause_valid) begin
      last_cause_reg <= evt.cause;
      unique case (evt.cause)
        RCT_CAUSE_PIN_SLEEP: begin
          timeout_flag_reg    <= 1'b1;
          power_down_flag_reg <= 1'b0;
        end
        RCT_CAUSE_DOG_RUN: begin
          timeout_flag_reg    <= 1'b0;
          power_down_flag_reg <= 1'b1;
        end
        RCT_CAUSE_DOG_WAKE: begin
          timeout_flag_reg    <= 1'b0;
          power_down_flag_reg <= 1'b0;
        end
        default: begin
          timeout_flag_reg    <= timeout_flag_reg;
          power_down_flag_reg <= power_down_flag_reg;
        end
      endcase
    end
  end

  // sticky event bits; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~evt_clr) | evt_set;
    end
  end

  // interrupt enable mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= '0;
    end else if (wr_done && idx == `RCT_IDX_IRQ_EN) begin
      irq_enable_reg <= pwdata[`RCT_EVT_W-1:0];
    end
  end

  // registered requests to the core and the interrupt level;
  // the wake pulse lags the cause by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_reg <= 1'b1;
      core_wake_reg  <= 1'b0;
      irq_reg        <= 1'b0;
    end else begin
      core_reset_reg <= load_defaults;
      core_wake_reg  <= evt.cause_valid && evt.cause == RCT_CAUSE_DOG_WAKE;
      irq_reg        <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // outputs straight from flops
  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign port_output_latch = port_output_latch_reg;
  assign port_direction    = port_direction_reg;
  assign option_settings   = option_reg;
  assign interrupt_control = intctl_reg;
  assign core_reset        = core_reset_reg;
  assign core_wake         = core_wake_reg;
  assign irq               = irq_reg;
endmodule : rct_top

// file: sim/rct_src_model.sv
`timescale 1ns/1ps
module rct_src_model (
  // clock
  input  wire logic pclk,
  // reset sources as seen by the block
  output logic      pin_n,
  output logic      dog,
  output logic      slp
);
  // quiet sources at time zero: pin high, no timeout, core awake
  initial begin
    pin_n = 1'b1;
    dog   = 1'b0;
    slp   = 1'b0;
  end

  // hold the pin low for n cycles, optionally with the core asleep
  task automatic hold_pin(input int n, input logic s);
    @(posedge pclk);
    slp   <= s;
    pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    pin_n <= 1'b1; // the pin is pulled high again, never left floating
  endtask : hold_pin

  // one-cycle watchdog timeout, run or sleep
  task automatic kick(input logic s);
    @(posedge pclk);
    slp <= s;
    dog <= 1'b1;
    @(posedge pclk);
    dog <= 1'b0;
    repeat (6) @(posedge pclk);
    slp <= 1'b0; // sleep held past the wake so the cause is not misread
  endtask : kick
endmodule : rct_src_model

// file: sim/rct_top_monitor.sv
`timescale 1ns/1ps
module rct_top_monitor (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // reset sources
  input wire logic       external_reset_pin_n,
  input wire logic       watchdog_timer_timeout,
  input wire logic       core_sleeping,
  // register contents and core requests
  input wire logic [7:0] port_output_latch,
  input wire logic [7:0] port_direction,
  input wire logic [7:0] option_settings,
  input wire logic [7:0] interrupt_control,
  input wire logic       core_reset,
  input wire logic       core_wake,
  input wire logic       irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] low_cnt; // consecutive low samples of the raw pin, saturating

  // count how long the pin has stayed low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 8'h00;
    else if (external_reset_pin_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end

  property p_dir_dflt; $fell(core_reset) |=> port_direction == 8'hFF; endproperty
  a_dir_dflt: assert property (p_dir_dflt) else $error("direction not all ones");
  property p_opt_dflt; $fell(core_reset) |=> option_settings == 8'hFF; endproperty
  a_opt_dflt: assert property (p_opt_dflt) else $error("option not all ones");
  property p_int_dflt; $fell(core_reset) |=> interrupt_control[7:1] == 7'h00; endproperty
  a_int_dflt: assert property (p_int_dflt) else $error("intctl upper bits set");
  property p_latch_keep; core_reset && $past(core_reset) |-> $stable(port_output_latch); endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch changed in reset");
  property p_dog_run;
    watchdog_timer_timeout && !core_sleeping && !core_reset |-> ##[1:4] core_reset;
  endproperty
  a_dog_run: assert property (p_dog_run) else $error("no reset after timeout");
  property p_dog_wake;
    watchdog_timer_timeout && core_sleeping && !core_reset |-> ##[1:4] core_wake;
  endproperty
  a_dog_wake: assert property (p_dog_wake) else $error("no wake after timeout");
  property p_wake_keep;
    core_wake |-> !core_reset ##1 ($stable(port_direction) && $stable(option_settings));
  endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("wake loaded defaults");
  property p_filt_min;
    $rose(core_reset) && !$past(watchdog_timer_timeout, 1) && !$past(watchdog_timer_timeout, 2)
      && !$past(watchdog_timer_timeout, 3) |-> low_cnt >= 8'd20;
  endproperty
  a_filt_min: assert property (p_filt_min) else $error("short pulse caused reset");
  property p_filt_max; low_cnt == 8'd28 |-> core_reset; endproperty
  a_filt_max: assert property (p_filt_max) else $error("long pulse ignored");

  // main scenarios seen
  c_wake: cover property (core_wake);
  c_pin:  cover property (low_cnt == 8'd28);
  c_irq:  cover property ($rose(irq));
endmodule : rct_top_monitor

bind rct_top rct_top_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .external_reset_pin_n(external_reset_pin_n),
  .watchdog_timer_timeout(watchdog_timer_timeout), .core_sleeping(core_sleeping),
  .port_output_latch(port_output_latch), .port_direction(port_direction),
  .option_settings(option_settings), .interrupt_control(interrupt_control),
  .core_reset(core_reset), .core_wake(core_wake), .irq(irq));

// file: sim/reset_cause_tracking_bench.sv
`timescale 1ns/1ps
`include "rct_defines.svh"
module reset_cause_tracking_bench;
  logic        pclk, presetn, psel, penable, pwrite; // apb master side
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr;
  logic        pin_n, dog, slp, core_reset, core_wake, irq; // sources and requests
  logic [7:0]  latch, dir, opt, ictl;
  int          err_total, total_checks;

  rct_src_model u_src (.pclk(pclk), .pin_n(pin_n), .dog(dog), .slp(slp));
  rct_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_reset_pin_n(pin_n), .watchdog_timer_timeout(dog),
    .core_sleeping(slp), .port_output_latch(latch), .port_direction(dir),
    .option_settings(opt), .interrupt_control(ictl), .core_reset(core_reset),
    .core_wake(core_wake), .irq(irq));

  // free-running 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // verdict and end of run, reached from the main flow or a timeout
  task automatic results();
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // one compare for every 32-bit result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // apb transfer: request held until pready is sampled high
  task automatic xfer(input logic w, input logic [13:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      results();
    end
    rdat = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer

  // read a register and compare, error response must stay low
  task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rdat, exp);
    chk({31'h0, rerr}, 32'h0);
  endtask : rd

  // wait until the core reset request is gone, bounded
  task automatic settle();
    int n;
    for (n = 0; n < 40 && core_reset !== 1'b0; n++) @(posedge pclk);
    if (n == 40) begin
      err_total++;
      results();
    end
    repeat (4) @(posedge pclk); // cause, flags and irq status land later than the request
  endtask : settle

  // last cause and timeout/power-down flags after an event
  task automatic cause(input logic [31:0] last, input logic [31:0] flg);
    rd(`RCT_IDX_LAST, last);
    rd(`RCT_IDX_FLAGS, flg);
  endtask : cause

  initial begin
    err_total = 0; total_checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 16'h0000; pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RCT_IDX_CAUSE_REG, 32'h0);
    rd(`RCT_IDX_DIR, 32'hFF);
    rd(`RCT_IDX_OPTION, 32'hFF);
    rd(`RCT_IDX_INTCTL_A, 32'h0);
    cause(32'h0, 32'h3);
    xfer(1'b1, `RCT_IDX_CAUSE_REG, 32'hFF);
    rd(`RCT_IDX_CAUSE_REG, 32'h2);
    xfer(1'b1, `RCT_IDX_PORT, 32'hA5);
    xfer(1'b1, `RCT_IDX_DIR, 32'h0F);
    xfer(1'b1, `RCT_IDX_OPTION, 32'h3C);
    xfer(1'b1, `RCT_IDX_INTCTL_B, 32'hFF);
    xfer(1'b1, `RCT_IDX_IRQ_EN, 32'hF);
    xfer(1'b1, `RCT_IDX_CONFIG, 32'h5A);
    u_src.hold_pin(10, 1'b0);             // a short glitch is filtered out
    settle();
    rd(`RCT_IDX_DIR, 32'h0F);
    cause(32'h0, 32'h3);
    u_src.hold_pin(30, 1'b0);             // pin reset while running
    settle();
    chk({31'h0, irq}, 32'h1);
    rd(`RCT_IDX_PORT, 32'hA5);
    rd(`RCT_IDX_CONFIG, 32'h5A);
    rd(`RCT_IDX_DIR, 32'hFF);
    rd(`RCT_IDX_OPTION, 32'hFF);
    rd(`RCT_IDX_INTCTL_A, 32'h1);
    rd(`RCT_IDX_CAUSE_REG, 32'h2);
    cause(32'h1, 32'h3);
    rd(`RCT_IDX_IRQ_STAT, 32'h1);
    xfer(1'b1, `RCT_IDX_IRQ_CLR, 32'hF);
    xfer(1'b1, `RCT_IDX_IRQ_EN, 32'h0);   // masked from here on
    xfer(1'b1, `RCT_IDX_DIR, 32'h0F);
    u_src.kick(1'b1);                     // watchdog wake-up from sleep
    settle();
    chk({31'h0, irq}, 32'h0);
    rd(`RCT_IDX_IRQ_STAT, 32'h8);
    rd(`RCT_IDX_DIR, 32'h0F);
    cause(32'h4, 32'h0);
    u_src.kick(1'b0);                     // watchdog reset while running
    settle();
    rd(`RCT_IDX_DIR, 32'hFF);
    cause(32'h3, 32'h1);
    u_src.hold_pin(30, 1'b1);             // pin reset during sleep
    settle();
    cause(32'h2, 32'h2);
    rd(`RCT_IDX_CAUSE_REG, 32'h2);
    xfer(1'b0, 14'h0123, 32'h0);          // unmapped place answers with an error
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;                      // second power-on in mid-run
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RCT_IDX_CAUSE_REG, 32'h0);
    cause(32'h0, 32'h3);
    results();
  end
endmodule : reset_cause_tracking_bench
